// file: design/raf_pkg.sv
package raf_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	localparam logic [7:0] OFS_CONV_READY_STATUS = 8'h32;
	localparam logic [7:0] OFS_RAIL2_ALERT_ENABLE = 8'h34;
	localparam logic [7:0] OFS_RAIL2_FAULT_FLAGS = 8'h35;

	localparam logic [7:0] RST_CONV_READY_STATUS = 8'h00;
	localparam logic [7:0] RST_RAIL2_ALERT_ENABLE = 8'h00;
	localparam logic [7:0] RST_RAIL2_FAULT_FLAGS = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// Converter status field positions.
	localparam int unsigned BIT_CUR_READY = 7;
	localparam int unsigned BIT_VOLT_READY = 6;
	localparam int unsigned CHAN_W = 6;

	// Rail-2 alert enable and fault flag positions, shared by both registers.
	localparam int unsigned BIT_POWER_MAX = 7;
	localparam int unsigned BIT_POWER_MIN = 6;
	localparam int unsigned BIT_SENSE_MAX = 5;
	localparam int unsigned BIT_SENSE_MIN = 4;
	localparam int unsigned BIT_VIN_MAX = 3;
	localparam int unsigned BIT_VIN_MIN = 2;
	localparam int unsigned BIT_AUX_MAX = 1;
	localparam int unsigned BIT_AUX_MIN = 0;

	// Data-ready alert enable positions within the misc enable input.
	localparam int unsigned MISC_VOLT_READY = 1;
	localparam int unsigned MISC_CUR_READY = 0;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} raf_reg_req_t;

	typedef struct packed {
		logic              cur_done;
		logic              volt_done;
		logic [CHAN_W-1:0] chan_new;
	} raf_conv_evt_t;

endpackage

// file: design/raf_rail2_alert_fault.sv
`timescale 1ns/1ns

module raf_rail2_alert_fault (
	input  wire logic                              sys_clk_i,
	input  wire logic                              rst_n_i,
	input  wire logic                              ce_i,
	input  wire raf_pkg::raf_reg_req_t             reg_req_i,
	input  wire raf_pkg::raf_conv_evt_t            conv_evt_i,
	input  wire logic [raf_pkg::DATA_W-1:0]        rail2_fault_cond_i,
	input  wire logic                              fault_clear_on_read_i,
	input  wire logic                              alert_clear_enable_i,
	input  wire logic                              addressed_i,
	input  wire logic [1:0]                        misc_alert_enable_bits_i,
	output logic [raf_pkg::DATA_W-1:0]             rdata_o,
	output logic                                   rvalid_o,
	output logic                                   alert_o,
	output logic [raf_pkg::DATA_W-1:0]             rail2_alert_enable_bits_o
);

	logic [raf_pkg::DATA_W-1:0] status_q;
	logic [raf_pkg::DATA_W-1:0] status_d;
	logic [raf_pkg::DATA_W-1:0] alert_en_q;
	logic [raf_pkg::DATA_W-1:0] fault_q;
	logic [raf_pkg::DATA_W-1:0] fault_d;
	logic [raf_pkg::DATA_W-1:0] status_set;
	logic [raf_pkg::DATA_W-1:0] fault_new;
	logic                       rd_status;
	logic                       rd_fault;
	logic                       wr_alert_en;
	logic                       wr_fault;
	logic                       alert_set;
	logic                       alert_q;

	function automatic logic hit(input raf_pkg::raf_reg_req_t r, input logic [7:0] ofs);
		hit = (r.addr == ofs);
	endfunction

	assign rd_status   = reg_req_i.rd && hit(reg_req_i, raf_pkg::OFS_CONV_READY_STATUS);
	assign rd_fault    = reg_req_i.rd && hit(reg_req_i, raf_pkg::OFS_RAIL2_FAULT_FLAGS);
	assign wr_alert_en = reg_req_i.wr && hit(reg_req_i, raf_pkg::OFS_RAIL2_ALERT_ENABLE);
	assign wr_fault    = reg_req_i.wr && hit(reg_req_i, raf_pkg::OFS_RAIL2_FAULT_FLAGS);

	// Converter completion events; a new event beats a simultaneous clearing read.
	always_comb begin
		status_set = {conv_evt_i.cur_done, conv_evt_i.volt_done, conv_evt_i.chan_new};
		status_d = status_q;
		if (rd_status) begin
			status_d = '0;
		end
		status_d = status_d | status_set;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			status_q <= raf_pkg::RST_CONV_READY_STATUS;
		end else if (ce_i) begin
			status_q <= status_d;
		end
	end

	// Each enable bit gates the alert from the fault of the same position; fault flags set regardless.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			alert_en_q <= raf_pkg::RST_RAIL2_ALERT_ENABLE;
		end else if (ce_i && wr_alert_en) begin
			alert_en_q <= reg_req_i.wdata;
		end
	end

	// Faults are sticky; writes and clearing reads lose to a live condition.
	always_comb begin
		fault_d = fault_q;
		if (wr_fault) begin
			fault_d = reg_req_i.wdata;
		end else if (rd_fault && fault_clear_on_read_i) begin
			fault_d = '0;
		end
		fault_d = fault_d | rail2_fault_cond_i;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			fault_q <= raf_pkg::RST_RAIL2_FAULT_FLAGS;
		end else if (ce_i) begin
			fault_q <= fault_d;
		end
	end

	assign fault_new = rail2_fault_cond_i & ~fault_q & alert_en_q;
	assign alert_set = (|fault_new)
		|| (conv_evt_i.volt_done && misc_alert_enable_bits_i[raf_pkg::MISC_VOLT_READY])
		|| (conv_evt_i.cur_done && misc_alert_enable_bits_i[raf_pkg::MISC_CUR_READY]);

	// A new alert cause wins over release by addressing in the same cycle.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			alert_q <= 1'b0;
		end else if (ce_i) begin
			if (alert_set) begin
				alert_q <= 1'b1;
			end else if (addressed_i && alert_clear_enable_i) begin
				alert_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_o  <= raf_pkg::UNMAPPED_READ_VALUE;
			rvalid_o <= 1'b0;
		end else if (ce_i) begin
			rvalid_o <= reg_req_i.rd;
			if (reg_req_i.rd) begin
				unique case (reg_req_i.addr)
					raf_pkg::OFS_CONV_READY_STATUS:  rdata_o <= status_q;
					raf_pkg::OFS_RAIL2_ALERT_ENABLE: rdata_o <= alert_en_q;
					raf_pkg::OFS_RAIL2_FAULT_FLAGS:  rdata_o <= fault_q;
					default:                         rdata_o <= raf_pkg::UNMAPPED_READ_VALUE;
				endcase
			end
		end
	end

	assign alert_o = alert_q;
	assign rail2_alert_enable_bits_o = alert_en_q;

	a_status_done_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && conv_evt_i.cur_done && conv_evt_i.volt_done
		|=> status_q[raf_pkg::BIT_CUR_READY] && status_q[raf_pkg::BIT_VOLT_READY])
		else $error("done bits not set");

	a_status_chan_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i |=> ((status_q[5:0] & $past(conv_evt_i.chan_new)) == $past(conv_evt_i.chan_new)))
		else $error("channel ready bit lost");

	a_status_read_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && rd_status && status_set == '0 |=> status_q == '0 && rvalid_o)
		else $error("status not cleared by read");

	a_alert_en_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && wr_alert_en |=> alert_en_q == $past(reg_req_i.wdata))
		else $error("alert enable write lost");

	a_enable_reset_zero: assert property (@(posedge sys_clk_i)
		!rst_n_i |=> alert_en_q == '0 && fault_q == '0 && !alert_o)
		else $error("reset values wrong");

	a_fault_sets: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && rail2_fault_cond_i != '0
		|=> (fault_q & $past(rail2_fault_cond_i)) == $past(rail2_fault_cond_i))
		else $error("fault flag not set");

	a_fault_sticky_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!wr_fault && !(rd_fault && fault_clear_on_read_i) |=> fault_q == ($past(fault_q)
		| ($past(ce_i) ? $past(rail2_fault_cond_i) : '0)))
		else $error("fault flag dropped");

	a_fault_read_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && rd_fault && fault_clear_on_read_i && !wr_fault && rail2_fault_cond_i == '0
		|=> fault_q == '0)
		else $error("fault not cleared on read");

	a_alert_fault_raise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && (rail2_fault_cond_i & ~fault_q & alert_en_q) != '0 |=> alert_o)
		else $error("enabled fault gave no alert");

	a_alert_ready_raise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && conv_evt_i.volt_done && misc_alert_enable_bits_i[raf_pkg::MISC_VOLT_READY]
		|=> alert_o)
		else $error("ready event gave no alert");

	a_alert_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && addressed_i && alert_clear_enable_i && !alert_set |=> !alert_o)
		else $error("alert not released");

	a_alert_cur_ready: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && conv_evt_i.cur_done && misc_alert_enable_bits_i[raf_pkg::MISC_CUR_READY]
		|=> alert_o)
		else $error("current ready event gave no alert");

	a_status_read_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && !rd_status |=> status_q == ($past(status_q) | $past(status_set)))
		else $error("status changed without a read");

	a_fault_write_store: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && wr_fault
		|=> fault_q == ($past(reg_req_i.wdata) | $past(rail2_fault_cond_i)))
		else $error("fault write not stored");

	a_fault_read_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && rd_fault |=> rdata_o == $past(fault_q) && rvalid_o)
		else $error("fault read data wrong");

	a_enable_read_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ce_i && reg_req_i.rd && hit(reg_req_i, raf_pkg::OFS_RAIL2_ALERT_ENABLE)
		|=> rdata_o == $past(alert_en_q))
		else $error("alert enable read data wrong");

	a_state_frozen: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(status_q) && $stable(fault_q)
		&& $stable(alert_en_q) && $stable(alert_q))
		else $error("state moved while clock enable low");

endmodule

// file: verification/raf_master_model.sv
`timescale 1ns/1ns
module raf_master_model (
	input  wire logic            sys_clk_i,
	output raf_pkg::raf_reg_req_t reg_req_o
);
	initial reg_req_o = '0;
	// Released address and data show their inverse so a stale value never looks valid.
	task automatic xfer(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		reg_req_o = '{rd: r, wr: w, addr: a, wdata: d};
		@(negedge sys_clk_i);
		reg_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

// file: verification/raf_rail2_alert_fault_tb.sv
`timescale 1ns/1ns
module raf_rail2_alert_fault_tb;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	raf_pkg::raf_reg_req_t  req;
	raf_pkg::raf_conv_evt_t evt = '0;
	logic [7:0]             cond = 8'h00;
	logic                   cor = 1'b0;
	logic                   ce = 1'b1;
	logic                   acl = 1'b0;
	logic                   adr = 1'b0;
	logic [1:0]             misc = 2'b00;
	logic [7:0]             rdata;
	logic                   rvalid;
	logic                   alert;
	logic [7:0]             en;
	logic [7:0]             val;
	int                     failures = 0;
	int                     compares = 0;

	always #5 clk = ~clk;

	raf_master_model raf_master_model_inst (.sys_clk_i(clk), .reg_req_o(req));
	raf_rail2_alert_fault raf_rail2_alert_fault_inst (
		.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_req_i(req), .conv_evt_i(evt),
		.rail2_fault_cond_i(cond), .fault_clear_on_read_i(cor), .alert_clear_enable_i(acl),
		.addressed_i(adr), .misc_alert_enable_bits_i(misc), .rdata_o(rdata),
		.rvalid_o(rvalid), .alert_o(alert), .rail2_alert_enable_bits_o(en));

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	function automatic logic [7:0] status_of(input raf_pkg::raf_conv_evt_t e);
		return {e.cur_done, e.volt_done, e.chan_new};
	endfunction

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		raf_master_model_inst.xfer(1'b1, 1'b0, a, 8'h00);
		chk("read data", rdata, e);
		chk("read valid", {7'h00, rvalid}, 8'h01);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		raf_master_model_inst.xfer(1'b0, 1'b1, a, d);
	endtask

	// Holds a stimulus for exactly one taking edge, then checks the alert.
	task automatic pulse(input logic [7:0] c, input logic a, input logic [7:0] e);
		@(negedge clk);
		cond = c;
		adr = a;
		@(negedge clk);
		cond = 8'h00;
		adr = 1'b0;
		chk("alert", {7'h00, alert}, e);
	endtask

	task automatic end_of_test;
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		val = 8'($urandom(32'h0077));
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		rd(8'h32, 8'h00);
		rd(8'h34, 8'h00);
		rd(8'h35, 8'h00);
		chk("enable out", en, 8'h00);
		rd(8'h33, 8'h00);
		wr(8'h32, 8'hff);
		rd(8'h32, 8'h00);
		val = 8'($urandom);
		wr(8'h34, val);
		rd(8'h34, val);
		chk("enable out", en, val);
		for (int k = 0; k < 5; k++) begin
			@(negedge clk);
			evt = (k == 0) ? 8'hff : 8'($urandom);
			val = status_of(evt);
			@(negedge clk);
			evt = '0;
			rd(8'h32, val);
			rd(8'h32, 8'h00);
		end
		wr(8'h34, 8'hff);
		acl = 1'b1;
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i, 1'b0, 8'h01);
			rd(8'h35, 8'h01 << i);
			pulse(8'h00, 1'b1, 8'h00);
			cor = 1'b1;
			rd(8'h35, 8'h01 << i);
			rd(8'h35, 8'h00);
			cor = 1'b0;
		end
		wr(8'h34, 8'h00);
		pulse(8'h3c, 1'b0, 8'h00);
		rd(8'h35, 8'h3c);
		wr(8'h35, 8'h00);
		rd(8'h35, 8'h00);
		misc = 2'b10;
		@(negedge clk);
		evt.volt_done = 1'b1;
		pulse(8'h00, 1'b0, 8'h01);
		evt = '0;
		rd(8'h32, 8'h40);
		misc = 2'b01;
		@(negedge clk);
		evt.cur_done = 1'b1;
		pulse(8'h00, 1'b1, 8'h01);
		evt = '0;
		misc = 2'b00;
		rd(8'h32, 8'h80);
		// With the clock enable low neither writes nor conditions nor releases may act.
		ce = 1'b0;
		wr(8'h34, 8'h5a);
		pulse(8'h80, 1'b1, 8'h01);
		ce = 1'b1;
		rd(8'h34, 8'h00);
		rd(8'h35, 8'h00);
		wr(8'h34, 8'hff);
		pulse(8'h81, 1'b1, 8'h01);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk("alert", {7'h00, alert}, 8'h00);
		chk("enable out", en, 8'h00);
		rd(8'h35, 8'h00);
		rd(8'h34, 8'h00);
		end_of_test;
	end

	initial begin
		#500000;
		failures++;
		end_of_test;
	end
endmodule
